// file: include/dbg_comms_pkg.sv
// Shared constants for the debug comms and monitor block
package dbg_comms_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_COMMS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TX_DATA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DEBUG_CTRL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MON_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_WP_CTRL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_WP_ADDR = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_WP_MASK = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_BP_ADDR = 8'h20;
    // Field positions
    localparam int BIT_READ_FULL = 0;
    localparam int BIT_WRITE_FULL = 1;
    localparam int BIT_MON_EN = 4;
    localparam int BIT_DBG_ABORT = 0;
    localparam int BIT_WP_EN = 0;
    localparam int BIT_WP_RW = 1;
    localparam int BIT_WP_RW_CARE = 2;
    localparam int BIT_WP_PRIV = 3;
    localparam int BIT_WP_PRIV_CARE = 4;
    localparam int BIT_WP_EXT = 5;
    localparam int BIT_WP_SIZE_LO = 6;
    localparam int BIT_WP_SIZE_CARE = 8;
    localparam int BIT_BP_EN = 9;
    localparam int BIT_BP_CHAIN = 10;
    localparam int BIT_BP_PRIV = 11;
    localparam int BIT_BP_PRIV_CARE = 12;
    localparam int BIT_BP_SIZE = 13;
    localparam int BIT_BP_SIZE_CARE = 14;
    localparam int WP_CTRL_W = 15;
    // Scan shift register length: 32 data bits, one direction bit
    localparam int SCAN_W = 33;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
endpackage

// file: logic/jtag_scan_port.sv
// Debugger-side scan port on the sampled JTAG clock
module jtag_scan_port
    import dbg_comms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tck,
    input wire logic tdi,
    input wire logic tms,
    output logic tdo,
    input wire logic [DATA_W-1:0] tx_word,
    input wire logic tx_full,
    input wire logic rx_full,
    output logic rx_load,
    output logic [DATA_W-1:0] rx_word,
    output logic tx_taken
);
    logic [2:0] tck_s;
    logic [1:0] tdi_s;
    logic [1:0] tms_s;
    logic [SCAN_W-1:0] shreg;
    logic [5:0] cnt;
    logic tck_rise;
    logic tck_fall;

    // --------------------------------------------------------------
    // Synchronisers and edge detect
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tck_s <= 3'h0;
            tdi_s <= 2'h0;
            tms_s <= 2'h0;
        end else begin
            tck_s <= {tck_s[1:0], tck};
            tdi_s <= {tdi_s[0], tdi};
            tms_s <= {tms_s[0], tms};
        end
    end
    assign tck_rise = tck_s[1] & ~tck_s[2];
    assign tck_fall = ~tck_s[1] & tck_s[2];

    // --------------------------------------------------------------
    // Frame: tms high; bit 32 set means write into receive word
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg <= '0;
            cnt <= 6'h00;
            rx_load <= 1'b0;
            rx_word <= ZERO_WORD;
            tx_taken <= 1'b0;
        end else begin
            rx_load <= 1'b0;
            tx_taken <= 1'b0;
            if (tck_rise && tms_s[1]) begin
                if (cnt == 6'h00) begin
                    shreg <= {tx_full, tx_word};
                    cnt <= 6'h01;
                end else begin
                    shreg <= {tdi_s[1], shreg[SCAN_W-1:1]};
                    if (cnt == 6'(SCAN_W)) begin
                        cnt <= 6'h00;
                        if (tdi_s[1]) begin
                            // Deposit only while the receive word is free
                            if (!rx_full) begin
                                rx_load <= 1'b1;
                                rx_word <= shreg[SCAN_W-1:1];
                            end
                        end else begin
                            tx_taken <= tx_full;
                        end
                    end else begin
                        cnt <= cnt + 6'h01;
                    end
                end
            end else if (tck_rise) begin
                cnt <= 6'h00;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tdo <= 1'b0;
        end else if (tck_fall) begin
            tdo <= shreg[0];
        end
    end
endmodule

// file: logic/watch_unit.sv
// One comparator unit for breakpoints or watchpoints
module watch_unit
    import dbg_comms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic upd,
    input wire logic enable,
    input wire logic [DATA_W-1:0] cmp_addr,
    input wire logic [DATA_W-1:0] cmp_mask,
    input wire logic [DATA_W-1:0] bus_addr,
    input wire logic valid,
    input wire logic qual_ok,
    output logic hit
);
    logic upd_q;

    // Suppress for the cycle of a register update and the cycle after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= upd;
        end
    end

    // Address compare only; no data value and no range compare
    always_comb begin
        hit = enable && valid && qual_ok && !upd && !upd_q &&
            (((bus_addr ^ cmp_addr) & ~cmp_mask) == ZERO_WORD);
    end
endmodule

// file: logic/debug_comms_monitor.sv
// Debug comms channel and monitor-mode abort logic with AXI4-Lite access
// Function
// - Read-full low while receive word empty
// - Debugger scan write sets read-full
// - Processor read of receive word clears read-full
// - Monitor mode only when bit four set
// - Breakpoint prefetch abort, watchpoint data abort
// - No data-value compare, no range compare
// - Qualify by address, external, privilege, direction, size
// - External condition qualifies watchpoints, and breakpoints only through the chain
// - Monitor abort sets debug abort flag
// - Core keeps running; watch registers stay writable
// - Watch register write suppresses matches that cycle
// - Processor write to transmit word sets write-full
// - Debugger scan read clears write-full
// - External abort wins, flag stays unchanged
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
module debug_comms_monitor
    import dbg_comms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tck,
    input wire logic tdi,
    input wire logic tms,
    output logic tdo,
    input wire logic [DATA_W-1:0] instr_addr,
    input wire logic instr_valid,
    input wire logic instr_privilege_indicator,
    input wire logic instr_state_size_indicator,
    input wire logic [DATA_W-1:0] data_addr,
    input wire logic data_valid,
    input wire logic data_write,
    input wire logic data_privilege_indicator,
    input wire logic [1:0] data_access_size,
    input wire logic external_watch_condition,
    input wire logic ext_abort_instr,
    input wire logic ext_abort_data,
    output logic prefetch_abort,
    output logic data_abort,
    output logic read_full,
    output logic write_full
);
    logic [DATA_W-1:0] rx_data;
    logic [DATA_W-1:0] tx_data;
    logic [DATA_W-1:0] debug_ctrl;
    logic [WP_CTRL_W-1:0] wp_ctrl;
    logic [DATA_W-1:0] wp_addr;
    logic [DATA_W-1:0] wp_mask;
    logic [DATA_W-1:0] bp_addr;
    logic debug_abort_flag;
    logic [1:0] ext_s;
    logic [ADDR_W-1:0] aw_addr;
    logic aw_have;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic w_have;
    logic wr_go;
    logic rd_go;
    logic coproc_read_transfer;
    logic rx_load;
    logic [DATA_W-1:0] rx_word;
    logic tx_taken;
    logic tx_load;
    logic mon_en;
    logic wp_upd;
    logic bp_upd;
    logic wp_qual;
    logic bp_qual;
    logic wp_hit;
    logic bp_hit;
    logic bp_raw;
    logic [DATA_W-1:0] next_word;

    // --------------------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------------------
    assign wr_go = aw_have && w_have && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            if (wr_go) begin
                aw_have <= 1'b0;
            end else if (s_axi_awvalid && !aw_have && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have <= 1'b0;
            w_data <= ZERO_WORD;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= 1'b0;
            if (wr_go) begin
                w_have <= 1'b0;
            end else if (s_axi_wvalid && !w_have && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                OFS_COMMS_CTRL, OFS_TX_DATA, OFS_DEBUG_CTRL, OFS_MON_STATUS,
                OFS_WP_CTRL, OFS_WP_ADDR, OFS_WP_MASK, OFS_BP_ADDR:
                    s_axi_bresp <= RESP_OKAY;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte-lane merge of the pending write onto an old value
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) begin
                r[i*8 +: 8] = w_data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        next_word = merge({{(DATA_W-WP_CTRL_W){1'b0}}, wp_ctrl});
    end

    assign tx_load = wr_go && aw_addr == OFS_TX_DATA;
    assign wp_upd = wr_go && (aw_addr == OFS_WP_CTRL ||
        aw_addr == OFS_WP_ADDR || aw_addr == OFS_WP_MASK);
    assign bp_upd = wr_go && (aw_addr == OFS_WP_CTRL ||
        aw_addr == OFS_BP_ADDR);

    // --------------------------------------------------------------
    // Configuration registers, writable while the core runs
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debug_ctrl <= ZERO_WORD;
            wp_ctrl <= '0;
            wp_addr <= ZERO_WORD;
            wp_mask <= ZERO_WORD;
            bp_addr <= ZERO_WORD;
            tx_data <= ZERO_WORD;
        end else if (wr_go) begin
            case (aw_addr)
                OFS_DEBUG_CTRL: debug_ctrl <= merge(debug_ctrl);
                OFS_WP_CTRL: wp_ctrl <= next_word[WP_CTRL_W-1:0];
                OFS_WP_ADDR: wp_addr <= merge(wp_addr);
                OFS_WP_MASK: wp_mask <= merge(wp_mask);
                OFS_BP_ADDR: bp_addr <= merge(bp_addr);
                OFS_TX_DATA: tx_data <= merge(tx_data);
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Comms flags; the setting event wins over the clear
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_full <= 1'b0;
            rx_data <= ZERO_WORD;
        end else if (rx_load) begin
            read_full <= 1'b1;
            rx_data <= rx_word;
        end else if (coproc_read_transfer) begin
            read_full <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_full <= 1'b0;
        end else if (tx_load) begin
            write_full <= 1'b1;
        end else if (tx_taken) begin
            write_full <= 1'b0;
        end
    end

    jtag_scan_port u_scan (
        .aclk(aclk),
        .aresetn(aresetn),
        .tck(tck),
        .tdi(tdi),
        .tms(tms),
        .tdo(tdo),
        .tx_word(tx_data),
        .tx_full(write_full),
        .rx_full(read_full),
        .rx_load(rx_load),
        .rx_word(rx_word),
        .tx_taken(tx_taken)
    );

    // --------------------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------------------
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign coproc_read_transfer = rd_go && s_axi_araddr == OFS_RX_DATA;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                !s_axi_rvalid;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= ZERO_WORD;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= ZERO_WORD;
            case (s_axi_araddr)
                OFS_COMMS_CTRL: begin
                    s_axi_rdata[BIT_READ_FULL] <= read_full;
                    s_axi_rdata[BIT_WRITE_FULL] <= write_full;
                end
                OFS_RX_DATA: s_axi_rdata <= rx_data;
                OFS_TX_DATA: s_axi_rdata <= tx_data;
                OFS_DEBUG_CTRL: s_axi_rdata <= debug_ctrl;
                OFS_MON_STATUS: s_axi_rdata[BIT_DBG_ABORT] <= debug_abort_flag;
                OFS_WP_CTRL: s_axi_rdata[WP_CTRL_W-1:0] <= wp_ctrl;
                OFS_WP_ADDR: s_axi_rdata <= wp_addr;
                OFS_WP_MASK: s_axi_rdata <= wp_mask;
                OFS_BP_ADDR: s_axi_rdata <= bp_addr;
                default: s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Monitor-mode match logic
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s <= 2'h0;
        end else begin
            ext_s <= {ext_s[0], external_watch_condition};
        end
    end
    assign mon_en = debug_ctrl[BIT_MON_EN];

    // Only these qualifiers exist
    always_comb begin
        wp_qual = (!wp_ctrl[BIT_WP_RW_CARE] ||
                   data_write == wp_ctrl[BIT_WP_RW]) &&
            (!wp_ctrl[BIT_WP_PRIV_CARE] ||
                   data_privilege_indicator == wp_ctrl[BIT_WP_PRIV]) &&
            (!wp_ctrl[BIT_WP_SIZE_CARE] ||
                   data_access_size == wp_ctrl[BIT_WP_SIZE_LO +: 2]) &&
            (!wp_ctrl[BIT_WP_EXT] || ext_s[1]);
        bp_qual = (!wp_ctrl[BIT_BP_PRIV_CARE] ||
                   instr_privilege_indicator == wp_ctrl[BIT_BP_PRIV]) &&
            (!wp_ctrl[BIT_BP_SIZE_CARE] ||
                   instr_state_size_indicator == wp_ctrl[BIT_BP_SIZE]);
    end

    watch_unit u_wp (
        .aclk(aclk),
        .aresetn(aresetn),
        .upd(wp_upd),
        .enable(wp_ctrl[BIT_WP_EN] && mon_en),
        .cmp_addr(wp_addr),
        .cmp_mask(wp_mask),
        .bus_addr(data_addr),
        .valid(data_valid),
        .qual_ok(wp_qual),
        .hit(wp_hit)
    );
    watch_unit u_bp (
        .aclk(aclk),
        .aresetn(aresetn),
        .upd(bp_upd),
        .enable(wp_ctrl[BIT_BP_EN] && mon_en),
        .cmp_addr(bp_addr),
        .cmp_mask(ZERO_WORD),
        .bus_addr(instr_addr),
        .valid(instr_valid),
        .qual_ok(bp_qual),
        .hit(bp_raw)
    );
    // Chained breakpoint needs the watchpoint condition as well
    assign bp_hit = bp_raw && (!wp_ctrl[BIT_BP_CHAIN] || wp_hit);

    // --------------------------------------------------------------
    // Abort outputs and sticky debug abort flag
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prefetch_abort <= 1'b0;
            data_abort <= 1'b0;
        end else begin
            prefetch_abort <= bp_hit || (instr_valid && ext_abort_instr);
            data_abort <= wp_hit || (data_valid && ext_abort_data);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debug_abort_flag <= 1'b0;
        end else if ((bp_hit && !ext_abort_instr) ||
                     (wp_hit && !ext_abort_data)) begin
            debug_abort_flag <= 1'b1;
        end else if (wr_go && aw_addr == OFS_MON_STATUS && w_strb[0]) begin
            debug_abort_flag <= w_data[BIT_DBG_ABORT];
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    AST_RX_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_load |=> read_full && rx_data == $past(rx_word))
        else $error("read-full not set after scan deposit");
    AST_RX_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
        coproc_read_transfer && !rx_load |=> !read_full)
        else $error("read-full not cleared by processor read");
    AST_NO_OVERRUN: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_load |-> !read_full)
        else $error("deposit while receive word full");
    AST_TX_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_load |=> write_full)
        else $error("write-full not set");
    AST_TX_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_taken && !tx_load |=> !write_full)
        else $error("write-full not cleared");
    AST_MON_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !mon_en |-> !bp_hit && !wp_hit)
        else $error("match outside monitor mode");
    AST_WP_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
        wp_hit |=> data_abort)
        else $error("watchpoint gave no data abort");
    AST_BP_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
        bp_hit |=> prefetch_abort)
        else $error("breakpoint gave no prefetch abort");
    AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        wp_hit && !ext_abort_data |=> debug_abort_flag)
        else $error("debug abort flag not set");
    AST_EXT_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
        !bp_hit && wp_hit && ext_abort_data && !wr_go |=> $stable(debug_abort_flag))
        else $error("flag changed under external abort");
    AST_UPD_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
        wp_upd |-> !wp_hit ##1 !wp_hit)
        else $error("watchpoint matched during update");
endmodule

// file: sim/debugger_model.sv
// Debugger model that moves words over the scan port
module debugger_model (
    output logic tck,
    output logic tdi,
    output logic tms,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {tck, tdi, tms} = 3'h0;
    // ------------------------------------------
    // Scan frame: load edge, then 33 shift edges
    // ------------------------------------------
    // Clock stands low between frames; tdi inverts once released
    // Start off the core clock edge; return once the frame has landed
    task automatic frame(input logic [32:0] v, output logic [32:0] q);
        #5;
        tms = 1'b1;
        for (int i = 0; i < 34; i++) begin
            if (i > 0) tdi = v[i-1];
            #100;
            if (i > 0) q[i-1] = tdo;
            tck = 1'b1;
            #60;
            tck = 1'b0;
        end
        tms = 1'b0;
        tdi = ~tdi;
        #100;
    endtask
endmodule

// file: sim/testbench.sv
// Self-checking bench for the debug comms and monitor block
module testbench
    import dbg_comms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a; logic [31:0] wd, rd;
        logic [1:0] rsp;} row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tck, tdi, tms, tdo;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, instr_addr, data_addr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, data_access_size, r;
    logic instr_valid, instr_privilege_indicator, instr_state_size_indicator;
    logic data_valid, data_write, data_privilege_indicator, ab;
    logic external_watch_condition, ext_abort_instr, ext_abort_data;
    logic prefetch_abort, data_abort, read_full, write_full;
    logic [32:0] q;
    int n_errors = 0;
    int checks_done = 0;
    row_t rows [4] = '{'{OFS_WP_ADDR, 32'h1234_5678, 32'h1234_5678, RESP_OKAY},
        '{OFS_WP_MASK, 32'h0f0f_00ff, 32'h0f0f_00ff, RESP_OKAY},
        '{OFS_BP_ADDR, 32'h8000_0104, 32'h8000_0104, RESP_OKAY},
        '{8'h40, 32'hdead_beef, ZERO_WORD, RESP_SLVERR}};
    debug_comms_monitor uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tck, .tdi, .tms, .tdo,
        .instr_addr, .instr_valid, .instr_privilege_indicator,
        .instr_state_size_indicator, .data_addr, .data_valid, .data_write,
        .data_privilege_indicator, .data_access_size,
        .external_watch_condition, .ext_abort_instr, .ext_abort_data,
        .prefetch_abort, .data_abort, .read_full, .write_full);
    debugger_model dbg (.tck, .tdi, .tms, .tdo);
    always #10 aclk = ~aclk;
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic stuck(input int n);
        if (n < 40) return;
        n_errors++;
        tally_and_finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        stuck(n);
    endtask
    task automatic rc(input logic [7:0] a, input logic [1:0] e,
            input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        stuck(n);
        check({s_axi_rresp, s_axi_rdata}, {e, d});
    endtask
    // Abort comes registered one cycle after the access cycle
    task automatic acc(input logic dt, input logic [31:0] a,
            input logic x, input logic e);
        @(posedge aclk);
        {instr_addr, data_addr} <= {a, a};
        {instr_valid, data_valid, ext_abort_instr, ext_abort_data} <=
            {!dt, dt, x, x};
        {instr_privilege_indicator, data_write} <= {x, !x};
        @(posedge aclk);
        {instr_valid, data_valid, ext_abort_instr, ext_abort_data} <= 4'h0;
        @(posedge aclk);
        ab = dt ? data_abort : prefetch_abort;
        if (e !== 1'bx) check(34'(ab), 34'(e));
    endtask
    // -------------
    // Main sequence
    // -------------
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, instr_valid, data_valid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {instr_addr, data_addr, s_axi_wstrb} = 68'hf;
        {instr_privilege_indicator, instr_state_size_indicator} = 2'h1;
        {data_write, data_privilege_indicator, data_access_size} = 4'ha;
        {external_watch_condition, ext_abort_instr, ext_abort_data} = 3'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            check({r, ZERO_WORD}, {rows[i].rsp, ZERO_WORD});
            rc(rows[i].a, rows[i].rsp, rows[i].rd);
        end
        check(34'(read_full), 34'h0);
        if (!read_full) dbg.frame({1'b1, 32'ha5c3_0f01}, q);
        check(34'(read_full), 34'h1);
        dbg.frame({1'b1, 32'h0bad_0bad}, q);
        rc(OFS_COMMS_CTRL, RESP_OKAY, 32'h1);
        rc(OFS_RX_DATA, RESP_OKAY, 32'ha5c3_0f01);
        @(posedge aclk);
        check(34'(read_full), 34'h0);
        wr(OFS_TX_DATA, 32'h3c5a_9612);
        @(posedge aclk);
        check(34'(write_full), 34'h1);
        dbg.frame(33'h0, q);
        check(34'(q), {2'h1, 32'h3c5a_9612});
        check(34'(write_full), 34'h0);
        wr(OFS_BP_ADDR, 32'h0000_0100);
        wr(OFS_WP_ADDR, 32'h0000_0200);
        wr(OFS_WP_MASK, ZERO_WORD);
        wr(OFS_WP_CTRL, 32'h0000_0201);
        acc(1'b0, 32'h0000_0100, 1'b0, 1'b0);
        wr(OFS_DEBUG_CTRL, 32'h0000_0010);
        acc(1'b0, 32'h0000_0104, 1'b0, 1'b0);
        acc(1'b0, 32'h0000_0100, 1'b0, 1'b1);
        rc(OFS_MON_STATUS, RESP_OKAY, 32'h1);
        acc(1'b1, 32'h0000_0200, 1'b0, 1'b1);
        data_valid <= 1'b1;
        wr(OFS_WP_MASK, ZERO_WORD);
        check(34'(data_abort), 34'h0);
        data_valid <= 1'b0;
        wr(OFS_MON_STATUS, ZERO_WORD);
        acc(1'b1, 32'h0000_0200, 1'b1, 1'b1);
        rc(OFS_MON_STATUS, RESP_OKAY, ZERO_WORD);
        wr(OFS_MON_STATUS, 32'h1);
        wr(OFS_TX_DATA, 32'h5555_aaaa);
        dbg.frame({1'b1, 32'h1}, q);
        check(34'({read_full, write_full}), 34'h3);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        check(34'({read_full, write_full}), 34'h0);
        aresetn <= 1'b1;
        rc(OFS_MON_STATUS, RESP_OKAY, ZERO_WORD);
        tally_and_finish;
    end
endmodule
